// >>> src/stcp_pkg.sv
// stcp_pkg: constants, encodings and timing for the serial to network packer.
// assumes a 100 MHz core clock and byte-wide serial data from logic on that clock.
package stcp_pkg;

	// ----------------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------------
	localparam int          CLK_PERIOD_NS  = 10;       // core clock period, ns
	localparam int          TICK_MS        = 1;        // time base tick, ms
	localparam int          MS_CYCLES      = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [15:0] MS_PER_MIN     = 16'hEA60; // 60000 ms in a minute
	localparam logic [15:0] KA_PERIOD_MS   = 16'h03E8; // probe after 1000 ms quiet
	localparam logic [15:0] KA_WAIT_MS     = 16'h01F4; // reply allowed 500 ms

	// ----------------------------------------------------------------------
	// sizes and reset values
	// ----------------------------------------------------------------------
	localparam logic [10:0] BUF_BYTES      = 11'h400;  // serial buffer, 1K bytes
	localparam logic [15:0] DEF_DEST_PORT  = 16'h0FA1; // port 4001
	localparam logic [7:0]  DEF_END_CHAR   = 8'h04;    // end character default
	localparam logic [15:0] DEF_CONNECT_MS = 16'h05DC; // 1500 ms
	localparam logic [6:0]  DEF_LINK_MIN   = 7'h07;    // 7 minutes
	localparam int          FIFO_DEPTH     = 16;       // frame fifo words
	localparam int          FIFO_WIDTH     = 9;        // {last, byte}

	// ----------------------------------------------------------------------
	// ascii codes
	// ----------------------------------------------------------------------
	localparam logic [7:0]  CH_CONNECT     = 8'h43;    // 'C'
	localparam logic [7:0]  CH_FAIL        = 8'h4E;    // 'N'
	localparam logic [7:0]  CH_DROP        = 8'h44;    // 'D'
	localparam logic [7:0]  CH_LF          = 8'h0A;
	localparam logic [7:0]  CH_CR          = 8'h0D;

	// ----------------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------------
	typedef enum logic [1:0] {
		STCP_CONN_ANY     = 2'h0, // first serial byte
		STCP_CONN_MANUAL  = 2'h1, // typed command
		STCP_CONN_STARTUP = 2'h2, // at power-on and again whenever idle
		STCP_CONN_DSR     = 2'h3  // dsr on
	} stcp_conn_mode_t;

	typedef enum logic [1:0] {
		STCP_TAIL_NONE = 2'h0,
		STCP_TAIL_ONE  = 2'h1,
		STCP_TAIL_TWO  = 2'h2
	} stcp_tail_t;

	typedef enum logic [2:0] {
		STCP_ST_IDLE = 3'b001,
		STCP_ST_WAIT = 3'b010,
		STCP_ST_OPEN = 3'b100
	} stcp_state_t;

endpackage

// >>> src/stcp_packer.sv
// stcp_packer: serial byte framing and outbound connection control, with its frame fifo.
// assumes the uart and network stack sit on core_clk; only the dsr pin is asynchronous.
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// frame fifo
// ----------------------------------------------------------------------------
module stcp_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               srst,
	// fill side
	input  wire logic               in_valid,
	output logic                    in_ready,
	input  wire logic [W-1:0]       in_data,
	output logic [$clog2(DEPTH):0]  level,
	// drain side, registered
	output logic                    out_valid,
	input  wire logic               out_ready,
	output logic [W-1:0]            out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];   // storage
	logic [AW-1:0] wr_ptr_r;      // write index
	logic [AW-1:0] rd_ptr_r;      // read index
	logic [AW:0]   cnt_r;         // words held in mem
	logic          ov_r;          // output stage valid
	logic [W-1:0]  od_r;          // output stage data

	// handshakes
	wire push = in_valid && in_ready;
	wire load = (cnt_r != '0) && (!ov_r || out_ready);

	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign level     = cnt_r;
	assign out_valid = ov_r;
	assign out_data  = od_r;

	// storage write
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// pointers, count and output stage
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
			ov_r     <= 1'b0;
			od_r     <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (load) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
				od_r     <= mem[rd_ptr_r];
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
			if (load) begin
				ov_r <= 1'b1;
			end else if (out_ready) begin
				ov_r <= 1'b0;
			end
		end
	end
endmodule

// ----------------------------------------------------------------------------
// packer top
// ----------------------------------------------------------------------------
module stcp_packer
	import stcp_pkg::*;
#(
	parameter int MS_DIV = MS_CYCLES  // cycles per 1 ms tick
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// serial bytes from host
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	output logic             rx_ready,
	input  wire logic        host_tx_activity,
	input  wire logic        dsr_pin,
	// status echo to host
	output logic             echo_valid,
	output logic [7:0]       echo_data,
	// manual command text to stack
	output logic             cmd_byte_valid,
	output logic [7:0]       cmd_byte_data,
	// framing configuration
	input  wire logic [10:0] cfg_pkt_len,
	input  wire logic [7:0]  cfg_delim1,
	input  wire logic [7:0]  cfg_delim2,
	input  wire logic        cfg_match_two,
	input  wire logic [1:0]  cfg_delim_tail,
	input  wire logic [15:0] cfg_flush_ms,
	// connection configuration
	input  wire logic [1:0]  cfg_conn_mode,
	input  wire logic        cfg_echo_enable,
	input  wire logic [15:0] cfg_connect_ms,
	input  wire logic        dsr_drop_disconnect,
	input  wire logic        end_char_close_enable,
	input  wire logic [7:0]  end_char_value,
	input  wire logic [15:0] cfg_serial_idle_ms,
	input  wire logic [6:0]  link_idle_minutes,
	input  wire logic [15:0] cfg_dest_port,
	// network stack control
	output logic             conn_open,
	output logic             conn_close,
	output logic [15:0]      conn_port,
	output logic             ka_probe,
	input  wire logic        net_up,
	input  wire logic        net_fail,
	input  wire logic        net_down,
	input  wire logic        net_activity,
	// frames to network
	output logic             net_valid,
	input  wire logic        net_ready,
	output logic [7:0]       net_data,
	output logic             net_last
);
	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	localparam int DW = $clog2(MS_DIV + 1);

	logic [DW-1:0]  div_r;         // tick divider
	logic           tick_r;        // 1 ms pulse
	logic [1:0]     dsr_sync_r;    // dsr synchroniser
	logic           pend_v_r;      // a byte is held back
	logic [7:0]     pend_d_r;      // held byte
	logic           pend_final_r;  // held byte closes frame
	logic [10:0]    cnt_r;         // bytes in current frame
	logic           prev_d1_r;     // last byte was first marker
	logic [1:0]     tail_r;        // tail bytes still due
	logic [15:0]    flush_ms_r;    // ms since last byte
	logic           rdy_r;         // registered rx_ready
	logic           cmd_act_r;     // inside a connect command
	stcp_state_t    st_r;          // connection state
	logic [15:0]    conn_ms_r;     // ms in connect attempt
	logic [15:0]    sidle_ms_r;    // ms without serial traffic
	logic [15:0]    ka_ms_r;       // ms without network traffic
	logic           ka_wait_r;     // probe outstanding
	logic [15:0]    min_ms_r;      // ms within current minute
	logic [6:0]     nidle_min_r;   // minutes without network traffic
	logic           open_r;
	logic           close_r;
	logic [15:0]    port_r;
	logic           probe_r;
	logic           echo_v_r;
	logic [7:0]     echo_d_r;
	logic           cmd_v_r;
	logic [7:0]     cmd_d_r;
	logic [4:0]     fifo_level;
	logic           fifo_in_ready;
	logic [8:0]     fifo_out;

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	wire dsr_on    = dsr_sync_r[1];
	wire st_idle   = (st_r == STCP_ST_IDLE);
	wire st_wait   = (st_r == STCP_ST_WAIT);
	wire st_open   = (st_r == STCP_ST_OPEN);
	wire rx_fire   = rx_valid && rdy_r;
	wire manual    = (cfg_conn_mode == STCP_CONN_MANUAL);
	wire cmd_take  = rx_fire && manual && st_idle && (cmd_act_r || rx_data == CH_CONNECT);
	wire cmd_done  = cmd_take && cmd_act_r && (rx_data == CH_LF);
	wire data_fire = rx_fire && !cmd_take;
	wire d1_en     = (cfg_delim1 != 8'h00);
	wire d2_en     = (cfg_delim2 != 8'h00);
	wire delim_on  = d1_en || d2_en;
	wire pair_mode = cfg_match_two && d1_en && d2_en;
	wire hit_pair  = prev_d1_r && (rx_data == cfg_delim2);
	wire hit_one   = (d1_en && rx_data == cfg_delim1) || (d2_en && rx_data == cfg_delim2);
	wire delim_hit = delim_on && (pair_mode ? hit_pair : hit_one);
	wire use_tail  = d1_en && (cfg_delim_tail != STCP_TAIL_NONE);
	wire tail_end  = (tail_r == 2'h1);
	wire len_hit   = (cfg_pkt_len != 11'h000) && (cnt_r + 11'h001 == cfg_pkt_len);
	wire buf_hit   = (cnt_r + 11'h001 == BUF_BYTES);
	wire end_now   = !delim_on || (delim_hit && !use_tail) || tail_end || len_hit || buf_hit;
	wire flush_hit = pend_v_r && !pend_final_r && (cfg_flush_ms != 16'h0000)
	               && (flush_ms_r == cfg_flush_ms);
	wire push      = (data_fire && pend_v_r) || (pend_v_r && pend_final_r && fifo_in_ready);
	wire pend_final_nxt = data_fire ? end_now : (push ? 1'b0 : (pend_final_r || flush_hit));
	wire serial_act = rx_fire || host_tx_activity;
	wire net_act   = net_activity || net_up;
	wire go_any    = (cfg_conn_mode == STCP_CONN_ANY) && rx_fire;
	wire go_start  = (cfg_conn_mode == STCP_CONN_STARTUP);
	wire go_dsr    = (cfg_conn_mode == STCP_CONN_DSR) && dsr_on;
	wire go_manual = manual && cmd_done;
	wire start_req = st_idle && (go_any || go_start || go_dsr || go_manual);
	wire conn_tmo  = st_wait && manual && (conn_ms_r >= cfg_connect_ms);
	wire drop_dsr  = dsr_drop_disconnect && !dsr_on;
	wire drop_end  = end_char_close_enable && rx_fire && (rx_data == end_char_value);
	wire drop_sid  = (cfg_serial_idle_ms != 16'h0000) && (sidle_ms_r >= cfg_serial_idle_ms);
	wire drop_ka   = ka_wait_r && (ka_ms_r >= KA_WAIT_MS);
	wire drop_nid  = (link_idle_minutes != 7'h00) && (nidle_min_r >= link_idle_minutes);
	wire self_drop = st_open && (drop_dsr || drop_end || drop_sid || drop_ka || drop_nid);

	// ------------------------------------------------------------------
	// time base and dsr synchroniser
	// ------------------------------------------------------------------
	// 1 ms tick that every timer counts
	always_ff @(posedge core_clk) begin
		if (srst) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (div_r == DW'(MS_DIV - 1));
			div_r  <= (div_r == DW'(MS_DIV - 1)) ? '0 : div_r + 1'b1;
		end
	end

	// two flops before anything reads dsr
	always_ff @(posedge core_clk) begin
		if (srst) begin
			dsr_sync_r <= 2'b00;
		end else begin
			dsr_sync_r <= {dsr_sync_r[0], dsr_pin};
		end
	end

	// ------------------------------------------------------------------
	// framing: one byte held back so its last flag can still change
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pend_v_r     <= 1'b0;
			pend_d_r     <= 8'h00;
			pend_final_r <= 1'b0;
			cnt_r        <= 11'h000;
			prev_d1_r    <= 1'b0;
			tail_r       <= 2'h0;
			rdy_r        <= 1'b0;
		end else begin
			pend_final_r <= pend_final_nxt;
			// one spare word covers the push made while rdy_r is stale
			rdy_r <= (fifo_level < 5'(FIFO_DEPTH - 1)) && !pend_final_nxt;
			if (data_fire) begin
				pend_v_r  <= 1'b1;
				pend_d_r  <= rx_data;
				cnt_r     <= end_now ? 11'h000 : cnt_r + 11'h001;
				prev_d1_r <= d1_en && (rx_data == cfg_delim1);
				if (delim_hit && use_tail) begin
					tail_r <= cfg_delim_tail;
				end else if (tail_r != 2'h0) begin
					tail_r <= tail_r - 2'h1;
				end
				if (end_now) begin
					tail_r <= 2'h0;
				end
			end else if (push) begin
				pend_v_r <= 1'b0;
			end
			// a flushed frame is closed, so the next one counts from zero
			if (flush_hit && !data_fire) begin
				cnt_r     <= 11'h000;
				prev_d1_r <= 1'b0;
				tail_r    <= 2'h0;
			end
		end
	end

	// gap counter for the idle flush
	always_ff @(posedge core_clk) begin
		if (srst || data_fire) begin
			flush_ms_r <= 16'h0000;
		end else if (tick_r && flush_ms_r != 16'hFFFF) begin
			flush_ms_r <= flush_ms_r + 16'h0001;
		end
	end

	stcp_fifo #(
		.W     (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.srst      (srst),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   ({pend_final_r, pend_d_r}),
		.level     (fifo_level),
		.out_valid (net_valid),
		.out_ready (net_ready),
		.out_data  (fifo_out)
	);

	// ------------------------------------------------------------------
	// connection state machine
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_r     <= STCP_ST_IDLE;
			open_r   <= 1'b0;
			close_r  <= 1'b0;
			echo_v_r <= 1'b0;
			echo_d_r <= 8'h00;
			port_r   <= DEF_DEST_PORT;
		end else begin
			open_r   <= 1'b0;
			close_r  <= 1'b0;
			echo_v_r <= 1'b0;
			case (st_r)
				STCP_ST_IDLE: begin
					if (start_req) begin
						st_r   <= STCP_ST_WAIT;
						open_r <= 1'b1;
						if (cfg_dest_port != 16'h0000) begin
							port_r <= cfg_dest_port;
						end
					end
				end
				STCP_ST_WAIT: begin
					if (net_up) begin
						st_r     <= STCP_ST_OPEN;
						echo_v_r <= cfg_echo_enable;
						echo_d_r <= CH_CONNECT;
					end else if (net_fail || conn_tmo) begin
						st_r     <= STCP_ST_IDLE;
						close_r  <= conn_tmo;
						echo_v_r <= cfg_echo_enable;
						echo_d_r <= CH_FAIL;
					end
				end
				STCP_ST_OPEN: begin
					if (net_down || self_drop) begin
						st_r     <= STCP_ST_IDLE;
						close_r  <= self_drop;
						echo_v_r <= cfg_echo_enable;
						echo_d_r <= CH_DROP;
					end
				end
				default: begin
					st_r <= STCP_ST_IDLE;
				end
			endcase
		end
	end

	// manual command capture, text passed on without the leading C, CR and LF
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cmd_act_r <= 1'b0;
			cmd_v_r   <= 1'b0;
			cmd_d_r   <= 8'h00;
		end else begin
			cmd_v_r <= cmd_take && cmd_act_r && rx_data != CH_LF && rx_data != CH_CR;
			if (cmd_take) begin
				cmd_d_r   <= rx_data;
				cmd_act_r <= !cmd_done;
			end else if (!st_idle || !manual) begin
				cmd_act_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// connection timers
	// ------------------------------------------------------------------
	// connect attempt length and serial idle time
	always_ff @(posedge core_clk) begin
		if (srst || !st_wait) begin
			conn_ms_r <= 16'h0000;
		end else if (tick_r && conn_ms_r != 16'hFFFF) begin
			conn_ms_r <= conn_ms_r + 16'h0001;
		end
		if (srst || !st_open || serial_act) begin
			sidle_ms_r <= 16'h0000;
		end else if (tick_r && sidle_ms_r != 16'hFFFF) begin
			sidle_ms_r <= sidle_ms_r + 16'h0001;
		end
	end

	// keep-alive: probe after a quiet period, expect traffic back
	always_ff @(posedge core_clk) begin
		if (srst || !st_open || net_act) begin
			ka_ms_r   <= 16'h0000;
			ka_wait_r <= 1'b0;
			probe_r   <= 1'b0;
		end else begin
			probe_r <= 1'b0;
			if (!ka_wait_r && ka_ms_r >= KA_PERIOD_MS) begin
				ka_wait_r <= 1'b1;
				probe_r   <= 1'b1;
				ka_ms_r   <= 16'h0000;
			end else if (tick_r) begin
				ka_ms_r <= ka_ms_r + 16'h0001;
			end
		end
	end

	// network idle in whole minutes
	always_ff @(posedge core_clk) begin
		if (srst || !st_open || net_act) begin
			min_ms_r    <= 16'h0000;
			nidle_min_r <= 7'h00;
		end else if (tick_r) begin
			if (min_ms_r == MS_PER_MIN - 16'h0001) begin
				min_ms_r <= 16'h0000;
				if (nidle_min_r != 7'h7F) begin
					nidle_min_r <= nidle_min_r + 7'h01;
				end
			end else begin
				min_ms_r <= min_ms_r + 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign rx_ready       = rdy_r;
	assign echo_valid     = echo_v_r;
	assign echo_data      = echo_d_r;
	assign cmd_byte_valid = cmd_v_r;
	assign cmd_byte_data  = cmd_d_r;
	assign conn_open      = open_r;
	assign conn_close     = close_r;
	assign conn_port      = port_r;
	assign ka_probe       = probe_r;
	assign net_data       = fifo_out[7:0];
	assign net_last       = fifo_out[8];

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence s_tail_two;
		data_fire && delim_hit && use_tail && cfg_delim_tail == STCP_TAIL_TWO;
	endsequence

	property p_nomark_final;
		@(posedge core_clk) disable iff (srst) data_fire && !delim_on |=> pend_final_r;
	endproperty
	a_nomark_final: assert property (p_nomark_final) else $error("byte not closed");

	property p_len_final;
		@(posedge core_clk) disable iff (srst) data_fire && len_hit |=> pend_final_r && cnt_r == 0;
	endproperty
	a_len_final: assert property (p_len_final) else $error("length cap missed");

	property p_buf_final;
		@(posedge core_clk) disable iff (srst) data_fire && cnt_r == 11'h3FF |=> pend_final_r;
	endproperty
	a_buf_final: assert property (p_buf_final) else $error("full buffer kept");

	property p_pair_order;
		@(posedge core_clk) disable iff (srst) data_fire && pair_mode && !prev_d1_r |-> !delim_hit;
	endproperty
	a_pair_order: assert property (p_pair_order) else $error("pair out of order");

	property p_one_byte;
		@(posedge core_clk) disable iff (srst)
			data_fire && !cfg_match_two && d2_en && rx_data == cfg_delim2 |-> delim_hit;
	endproperty
	a_one_byte: assert property (p_one_byte) else $error("single marker missed");

	property p_tail_two;
		@(posedge core_clk) disable iff (srst) s_tail_two |=> tail_r == 2'h2 && !pend_final_r;
	endproperty
	a_tail_two: assert property (p_tail_two) else $error("tail not armed");

	property p_flush;
		@(posedge core_clk) disable iff (srst) flush_hit && !data_fire |=> pend_final_r;
	endproperty
	a_flush: assert property (p_flush) else $error("idle flush lost");

	property p_startup;
		@(posedge core_clk) disable iff (srst) st_idle && go_start |=> conn_open && st_wait;
	endproperty
	a_startup: assert property (p_startup) else $error("no start-up connect");

	property p_conn_tmo;
		@(posedge core_clk) disable iff (srst)
			conn_tmo && !net_up |=> st_idle && conn_close ##1 !conn_close;
	endproperty
	a_conn_tmo: assert property (p_conn_tmo) else $error("attempt not aborted");

	property p_end_char;
		@(posedge core_clk) disable iff (srst)
			st_open && drop_end |=> st_idle && conn_close && echo_valid == cfg_echo_enable;
	endproperty
	a_end_char: assert property (p_end_char) else $error("end char ignored");

	property p_echo_up;
		@(posedge core_clk) disable iff (srst)
			st_wait && net_up && cfg_echo_enable |=> echo_valid && echo_data == CH_CONNECT;
	endproperty
	a_echo_up: assert property (p_echo_up) else $error("no connect echo");

	property p_dsr_drop;
		@(posedge core_clk) disable iff (srst) st_open && drop_dsr |=> st_idle;
	endproperty
	a_dsr_drop: assert property (p_dsr_drop) else $error("dsr off ignored");
endmodule

// >>> verif/stcp_host_model.sv
// stcp_host_model: host processor side of the serial byte port.
// assumes callers enter send just after a rising edge of core_clk.
`timescale 1ns/1ps
module stcp_host_model (
	// clock and handshake
	input  wire logic       core_clk,
	input  wire logic       rx_ready,
	// serial byte and dsr line
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            dsr_pin
);
	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		dsr_pin  = 1'b0;
	end
	// offer one byte, hold until taken, then scramble the released data
	task automatic send(input logic [7:0] b);
		logic ok;
		rx_valid = 1'b1;
		rx_data  = b;
		do begin
			ok = rx_ready;
			@(posedge core_clk);
			#1;
		end while (ok !== 1'b1);
		rx_valid = 1'b0;
		rx_data  = ~b;
		// one edge passes so a following byte never re-raises valid in the same step
		@(posedge core_clk);
		#1;
	endtask
	// drive the dsr level
	task automatic set_dsr(input logic v);
		dsr_pin = v;
	endtask
endmodule

// >>> verif/tb.sv
// tb: reset, then table-driven framing cases, then connection control.
// assumes stcp_host_model stands in for the host serial side.
`timescale 1ns/1ps
module tb;
	import stcp_pkg::*;
	typedef struct {logic [7:0] d1, d2; logic m2; logic [1:0] tl; logic [10:0] len;
		logic [31:0] by; logic [3:0] lm;} stcp_row_t;
	logic core_clk = 0, srst = 1, net_ready = 1, net_up = 0, net_fail = 0, net_down = 0;
	logic net_activity = 0, host_tx_activity = 0, rx_valid, rx_ready, dsr_pin, cfg_match_two;
	logic echo_valid, cmd_byte_valid, conn_open, conn_close, ka_probe, net_valid, net_last;
	logic cfg_echo_enable = 1, dsr_drop_disconnect = 0, end_char_close_enable = 0;
	logic [7:0] rx_data, cfg_delim1, cfg_delim2, echo_data, cmd_byte_data, net_data, last_echo;
	logic [7:0] end_char_value = 8'h04;
	logic [10:0] cfg_pkt_len;
	logic [1:0] cfg_delim_tail, cfg_conn_mode = 2'h2;
	logic [15:0] cfg_flush_ms = 16'h0003, cfg_connect_ms = 16'h05DC;
	logic [15:0] cfg_serial_idle_ms = 16'h07D0; // longer than flush and any open span
	logic [15:0] cfg_dest_port = 16'h0FA1, conn_port;
	logic [6:0] link_idle_minutes = 7'h07;
	logic [8:0] q[$];
	int mismatches = 0, checked = 0, n_open = 0, n_close = 0, n_probe = 0, n_mark = 0;
	logic [23:0] cmd_s = '0;
	logic [7:0] cmd_txt[5] = '{8'h43, 8'h31, 8'h2F, 8'h32, 8'h0A};
	stcp_row_t rows[10] = '{
		'{0, 0, 1, 0, 0, 32'h11223344, 4'hF},
		'{8'h2A, 0, 1, 0, 0, 32'h112A2233, 4'hA},
		'{8'h2A, 8'h2B, 1, 0, 0, 32'h2A2B1122, 4'hA},
		'{8'h2A, 8'h2B, 1, 0, 0, 32'h2B2A1122, 4'h8},
		'{8'h2A, 8'h2B, 0, 0, 0, 32'h112B2233, 4'hA},
		'{8'h2A, 0, 1, 1, 0, 32'h2A112233, 4'hA},
		'{8'h2A, 0, 1, 2, 0, 32'h2A112233, 4'hC},
		'{8'h2A, 8'h2B, 1, 2, 0, 32'h2A2B1122, 4'h8},
		'{0, 8'h2A, 0, 1, 0, 32'h112A2233, 4'hA},
		'{8'h2A, 0, 1, 0, 11'h002, 32'h11223344, 4'hA}
	};
	always #5 core_clk = ~core_clk;
	stcp_packer #(.MS_DIV(10)) uut (
		.core_clk(core_clk), .srst(srst), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .host_tx_activity(host_tx_activity), .dsr_pin(dsr_pin),
		.echo_valid(echo_valid), .echo_data(echo_data), .cmd_byte_valid(cmd_byte_valid),
		.cmd_byte_data(cmd_byte_data), .cfg_pkt_len(cfg_pkt_len), .cfg_delim1(cfg_delim1),
		.cfg_delim2(cfg_delim2), .cfg_match_two(cfg_match_two),
		.cfg_delim_tail(cfg_delim_tail), .cfg_flush_ms(cfg_flush_ms),
		.cfg_conn_mode(cfg_conn_mode), .cfg_echo_enable(cfg_echo_enable),
		.cfg_connect_ms(cfg_connect_ms), .dsr_drop_disconnect(dsr_drop_disconnect),
		.end_char_close_enable(end_char_close_enable), .end_char_value(end_char_value),
		.cfg_serial_idle_ms(cfg_serial_idle_ms), .link_idle_minutes(link_idle_minutes),
		.cfg_dest_port(cfg_dest_port), .conn_open(conn_open), .conn_close(conn_close),
		.conn_port(conn_port), .ka_probe(ka_probe), .net_up(net_up), .net_fail(net_fail),
		.net_down(net_down), .net_activity(net_activity), .net_valid(net_valid),
		.net_ready(net_ready), .net_data(net_data), .net_last(net_last)
	);
	stcp_host_model host (.core_clk(core_clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .dsr_pin(dsr_pin));
	// capture frame stream and control pulses
	always @(posedge core_clk) begin
		if (net_valid === 1'b1) q.push_back({net_last, net_data});
		if (echo_valid === 1'b1) last_echo = echo_data;
		if (conn_open === 1'b1) n_open++;
		if (conn_close === 1'b1) n_close++;
		if (ka_probe === 1'b1) n_probe++;
		if (cmd_byte_valid === 1'b1) cmd_s = {cmd_s[15:0], cmd_byte_data};
	end
	task automatic chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#400000;
		mismatches++;
		finish_test;
	end
	initial begin
		wt(4);
		chk(conn_port === 16'h0FA1 && net_valid === 1'b0, "reset values");
		srst = 1'b0;
		wt(3);
		chk(n_open > 0, "start-up open missing");
		$display("test reset done");
		foreach (rows[i]) begin
			{cfg_delim1, cfg_delim2, cfg_match_two} = {rows[i].d1, rows[i].d2, rows[i].m2};
			{cfg_delim_tail, cfg_pkt_len} = {rows[i].tl, rows[i].len};
			q.delete();
			for (int k = 0; k < 4; k++) host.send(rows[i].by[31-8*k -: 8]);
			wt(60);
			chk(q.size() == 4, "frame byte count");
			for (int k = 0; k < 4; k++)
				chk(q[k] === {rows[i].lm[k], rows[i].by[31-8*k -: 8]}, "frame byte");
			$display("test row %0d done", i);
		end
		net_up = 1'b1;
		wt(1);
		net_up = 1'b0;
		wt(3);
		chk(last_echo === CH_CONNECT, "connect echo");
		end_char_close_enable = 1'b1;
		cfg_dest_port = 16'h1234;
		host.send(8'h04);
		wt(5);
		chk(n_close > 0 && last_echo === CH_DROP, "end char close");
		wt(5);
		chk(conn_port === 16'h1234, "port reload");
		// open, then stay silent until the keep-alive gives up
		net_up = 1'b1;
		wt(1);
		net_up = 1'b0;
		wt(16000);
		chk(n_probe == 1 && n_close == 2, "keep-alive close");
		// attempt opened in start-up mode runs out of time once the mode is manual
		cfg_conn_mode = STCP_CONN_MANUAL;
		cfg_connect_ms = 16'h0064;
		wt(1100);
		chk(n_close == 3 && last_echo === CH_FAIL, "connect timeout");
		foreach (cmd_txt[k]) host.send(cmd_txt[k]);
		net_up = 1'b1;
		wt(1);
		net_up = 1'b0;
		wt(3);
		chk(cmd_s === 24'h312F32 && last_echo === CH_CONNECT, "manual connect");
		// dsr off closes, dsr on reconnects
		host.set_dsr(1'b1);
		wt(5);
		dsr_drop_disconnect = 1'b1;
		cfg_conn_mode = STCP_CONN_DSR;
		host.set_dsr(1'b0);
		wt(6);
		chk(n_close == 4 && last_echo === CH_DROP, "dsr off close");
		n_mark = n_open;
		host.set_dsr(1'b1);
		wt(6);
		chk(n_open == n_mark + 1, "dsr connect");
		$display("test connection done");
		finish_test;
	end
endmodule
